/* pkg/arf_pkg.sv */
// shared constants and carriers for the converter result and gain block
package arf_pkg;

    // *****************************************************
    // register addresses on the special function port
    // *****************************************************
    localparam logic [7:0] ARF_ADDR_CTL   = 8'hE8;
    localparam logic [7:0] ARF_ADDR_CFG   = 8'hBC;
    localparam logic [7:0] ARF_ADDR_RES_L = 8'hBD;
    localparam logic [7:0] ARF_ADDR_RES_H = 8'hBE;

    // *****************************************************
    // indirect gain register addresses
    // *****************************************************
    localparam logic [7:0] ARF_GADDR_HIGH  = 8'h04;
    localparam logic [7:0] ARF_GADDR_LOW   = 8'h07;
    localparam logic [7:0] ARF_GADDR_EXTRA = 8'h08;

    // *****************************************************
    // field positions
    // *****************************************************
    localparam int ARF_CTL_LJST_BIT  = 2;
    localparam int ARF_CFG_GAIN_ACCESS_ENABLE    = 0;
    localparam int ARF_CFG_RPT_LO    = 1;
    localparam int ARF_CFG_RPT_HI    = 2;
    localparam int ARF_GNA_ADD_BIT   = 0;
    localparam int ARF_CODE_W        = 12;
    localparam int ARF_JUST_SHIFT    = 4;

    // *****************************************************
    // reset values
    // *****************************************************
    localparam logic [7:0]  ARF_CTL_RST   = 8'h00;
    localparam logic [7:0]  ARF_CFG_RST   = 8'hF8;
    localparam logic [7:0]  ARF_GHI_RST   = 8'hFC;
    localparam logic [7:0]  ARF_GLO_RST   = 8'h00;
    localparam logic        ARF_GADD_RST  = 1'b1;
    localparam logic [15:0] ARF_RES_RST   = 16'h0000;
    localparam logic [7:0]  ARF_GADDR_RST = 8'h00;

    // *****************************************************
    // repeat count select encodings
    // *****************************************************
    localparam logic [1:0] ARF_RPT_1  = 2'h0;
    localparam logic [1:0] ARF_RPT_4  = 2'h1;
    localparam logic [1:0] ARF_RPT_8  = 2'h2;
    localparam logic [1:0] ARF_RPT_16 = 2'h3;

    // *****************************************************
    // carriers
    // *****************************************************
    typedef struct packed {
        logic       we;
        logic       re;
        logic [7:0] addr;
        logic [7:0] wdata;
    } arf_sfr_req_type;

    typedef struct packed {
        logic        valid;
        logic [11:0] code;
    } arf_sample_type;

    typedef struct packed {
        logic [11:0] word;
        logic        sixtyfourth_gain_add;
    } arf_gain_type;

endpackage : arf_pkg

/* logic/arf_result_gain.sv */
// result formatting, accumulation and indirect gain registers of the converter
// Notes on behaviour
// - result split over high and low bytes
// - repeat one: 12-bit result every conversion
// - left justify shifts code up four places
// - unused result bits read zero after a single conversion
// - repeat above one: update after last sample
// - accumulated result is the true sum
// - sample count from repeat count select field
// - gain selectable from zero to 1.016
// - gain is thirteen bits in three registers
// - gain word is high byte then nibble
// - extra bit adds one sixty-fourth gain
// - extra gain bit is one after reset
// - gain access redirects result byte writes
// - high byte write addresses, low writes data
// - gain addresses 0x04, 0x07, 0x08
// - gain registers cannot be read back
`timescale 1ns/10ps

module arf_result_gain
    import arf_pkg::*;
(
    input  wire logic            mclk,
    input  wire logic            rst,
    input  wire arf_sfr_req_type sfr_req,
    output logic [7:0]           sfr_rdata,
    input  wire arf_sample_type  sample,
    output logic                 result_valid,
    output logic [15:0]          result_word,
    output arf_gain_type         gain,
    output logic                 gain_access_enable,
    output logic [1:0]           repeat_count_select,
    output logic                 left_justify_select
);

    // *****************************************************
    // state
    // *****************************************************
    typedef struct packed {
        logic [7:0]  ctl;
        logic [7:0]  cfg;
        logic [15:0] res;
        logic [15:0] acc;
        logic [3:0]  cnt;
        logic [7:0]  gaddr;
        logic [7:0]  ghi;
        logic [7:0]  glo;
        logic        gadd;
        logic        rvalid;
        logic [7:0]  rdata;
    } arf_state_type;

    arf_state_type st_q;
    arf_state_type st_d;

    // last sample index of a series
    function automatic logic [3:0] arf_last_index(input logic [1:0] sel);
        case (sel)
            ARF_RPT_4:  arf_last_index = 4'h3;
            ARF_RPT_8:  arf_last_index = 4'h7;
            ARF_RPT_16: arf_last_index = 4'hF;
            default:    arf_last_index = 4'h0;
        endcase
    endfunction : arf_last_index

    // aligned single sample
    function automatic logic [15:0] arf_align(input logic [11:0] code, input logic lj);
        if (lj)
        begin
            arf_align = {code, 4'h0};
        end
        else
        begin
            arf_align = {4'h0, code};
        end
    endfunction : arf_align

    logic        gen;
    logic        lj;
    logic [1:0]  rpt;
    logic [15:0] sum;
    logic        wr_h;
    logic        wr_l;

    assign gen  = st_q.cfg[ARF_CFG_GAIN_ACCESS_ENABLE];
    assign lj   = st_q.ctl[ARF_CTL_LJST_BIT];
    assign rpt  = st_q.cfg[ARF_CFG_RPT_HI:ARF_CFG_RPT_LO];
    assign sum  = st_q.acc + {4'h0, sample.code};
    assign wr_h = sfr_req.we && (sfr_req.addr == ARF_ADDR_RES_H);
    assign wr_l = sfr_req.we && (sfr_req.addr == ARF_ADDR_RES_L);

    // *****************************************************
    // next state
    // *****************************************************
    always_comb
    begin
        st_d        = st_q;
        st_d.rvalid = 1'b0;
        if (sfr_req.we && sfr_req.addr == ARF_ADDR_CTL)
        begin
            st_d.ctl = sfr_req.wdata;
        end
        if (sfr_req.we && sfr_req.addr == ARF_ADDR_CFG)
        begin
            st_d.cfg = sfr_req.wdata;
        end
        if (wr_h)
        begin
            if (gen)
            begin
                st_d.gaddr = sfr_req.wdata;
            end
            else
            begin
                st_d.res[15:8] = sfr_req.wdata;
            end
        end
        if (wr_l)
        begin
            if (gen)
            begin
                case (st_q.gaddr)
                    ARF_GADDR_HIGH:  st_d.ghi = sfr_req.wdata;
                    ARF_GADDR_LOW:   st_d.glo = {sfr_req.wdata[7:4], 4'h0};
                    ARF_GADDR_EXTRA: st_d.gadd = sfr_req.wdata[ARF_GNA_ADD_BIT];
                    default:         st_d.gaddr = st_q.gaddr;
                endcase
            end
            else
            begin
                st_d.res[7:0] = sfr_req.wdata;
            end
        end
        // conversion results take priority over a plain result write
        if (sample.valid)
        begin
            if (rpt == ARF_RPT_1)
            begin
                st_d.res    = arf_align(sample.code, lj);
                st_d.rvalid = 1'b1;
                st_d.acc    = 16'h0000;
                st_d.cnt    = 4'h0;
            end
            else if (st_q.cnt >= arf_last_index(rpt))
            begin
                st_d.res    = sum;
                st_d.rvalid = 1'b1;
                st_d.acc    = 16'h0000;
                st_d.cnt    = 4'h0;
            end
            else
            begin
                st_d.acc = sum;
                st_d.cnt = st_q.cnt + 4'h1;
            end
        end
        // read data; gain registers have no read path
        if (sfr_req.re)
        begin
            case (sfr_req.addr)
                ARF_ADDR_CTL:   st_d.rdata = st_q.ctl;
                ARF_ADDR_CFG:   st_d.rdata = st_q.cfg;
                ARF_ADDR_RES_H: st_d.rdata = st_q.res[15:8];
                ARF_ADDR_RES_L: st_d.rdata = st_q.res[7:0];
                default:        st_d.rdata = 8'h00;
            endcase
        end
    end

    // *****************************************************
    // registers
    // *****************************************************
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            st_q.ctl    <= ARF_CTL_RST;
            st_q.cfg    <= ARF_CFG_RST;
            st_q.res    <= ARF_RES_RST;
            st_q.acc    <= 16'h0000;
            st_q.cnt    <= 4'h0;
            st_q.gaddr  <= ARF_GADDR_RST;
            st_q.ghi    <= ARF_GHI_RST;
            st_q.glo    <= ARF_GLO_RST;
            st_q.gadd   <= ARF_GADD_RST;
            st_q.rvalid <= 1'b0;
            st_q.rdata  <= 8'h00;
        end
        else
        begin
            st_q <= st_d;
        end
    end

    // *****************************************************
    // outputs
    // *****************************************************
    assign sfr_rdata                 = st_q.rdata;
    assign result_valid              = st_q.rvalid;
    assign result_word               = st_q.res;
    assign gain.word                 = {st_q.ghi, st_q.glo[7:4]};
    assign gain.sixtyfourth_gain_add = st_q.gadd;
    assign gain_access_enable        = gen;
    assign repeat_count_select       = rpt;
    assign left_justify_select       = lj;

    // *****************************************************
    // assertions
    // *****************************************************
    sequence s_single_sample;
        sample.valid && rpt == ARF_RPT_1;
    endsequence

    property p_single_update;
        @(posedge mclk) disable iff (rst)
        s_single_sample |=> result_valid && result_word == arf_align($past(sample.code), $past(lj));
    endproperty
    a_single_update: assert property (p_single_update) else $error("single result wrong");

    property p_unused_zero;
        @(posedge mclk) disable iff (rst)
        s_single_sample |=> ($past(lj) ? result_word[3:0] == 4'h0 : result_word[15:12] == 4'h0);
    endproperty
    a_unused_zero: assert property (p_unused_zero) else $error("unused result bits set");

    property p_accum_hold;
        @(posedge mclk) disable iff (rst)
        sample.valid && rpt != ARF_RPT_1 && st_q.cnt < arf_last_index(rpt) && !wr_h && !wr_l
        |=> !result_valid && $stable(result_word);
    endproperty
    a_accum_hold: assert property (p_accum_hold) else $error("result moved mid series");

    property p_first_sum;
        @(posedge mclk) disable iff (rst)
        sample.valid && rpt != ARF_RPT_1 && st_q.cnt == 4'h0 |=> st_q.acc == {4'h0, $past(sample.code)};
    endproperty
    a_first_sum: assert property (p_first_sum) else $error("accumulator start wrong");

    property p_series_len;
        @(posedge mclk) disable iff (rst)
        sample.valid && rpt == ARF_RPT_4 && st_q.cnt == 4'h3 |=> result_valid && st_q.cnt == 4'h0;
    endproperty
    a_series_len: assert property (p_series_len) else $error("series of four mis-counted");

    property p_gain_addr;
        @(posedge mclk) disable iff (rst)
        wr_h && gen |=> st_q.gaddr == $past(sfr_req.wdata) && result_word[15:8] == $past(result_word[15:8])
        || $past(sample.valid);
    endproperty
    a_gain_addr: assert property (p_gain_addr) else $error("gain address not captured");

    property p_gain_high;
        @(posedge mclk) disable iff (rst)
        wr_l && gen && st_q.gaddr == ARF_GADDR_HIGH |=> gain.word[11:4] == $past(sfr_req.wdata);
    endproperty
    a_gain_high: assert property (p_gain_high) else $error("gain high not loaded");

    property p_gain_unmatched;
        @(posedge mclk) disable iff (rst)
        !(wr_l && gen && (st_q.gaddr == ARF_GADDR_HIGH || st_q.gaddr == ARF_GADDR_LOW
        || st_q.gaddr == ARF_GADDR_EXTRA)) |=> $stable(gain);
    endproperty
    a_gain_unmatched: assert property (p_gain_unmatched) else $error("gain changed without write");

    property p_read_res;
        @(posedge mclk) disable iff (rst)
        sfr_req.re && sfr_req.addr == ARF_ADDR_RES_H |=> sfr_rdata == $past(result_word[15:8]);
    endproperty
    a_read_res: assert property (p_read_res) else $error("high byte read wrong");

    sequence s_gain_data_write;
        wr_l && gen;
    endsequence

    sequence s_series_end;
        sample.valid && rpt != ARF_RPT_1 && st_q.cnt >= arf_last_index(rpt);
    endsequence

    property p_gain_low;
        @(posedge mclk) disable iff (rst)
        s_gain_data_write ##0 st_q.gaddr == ARF_GADDR_LOW
        |=> gain.word[3:0] == $past(sfr_req.wdata[7:4]);
    endproperty
    a_gain_low: assert property (p_gain_low) else $error("gain low not loaded");

    property p_gain_extra;
        @(posedge mclk) disable iff (rst)
        s_gain_data_write ##0 st_q.gaddr == ARF_GADDR_EXTRA
        |=> gain.sixtyfourth_gain_add == $past(sfr_req.wdata[ARF_GNA_ADD_BIT]);
    endproperty
    a_gain_extra: assert property (p_gain_extra) else $error("extra gain not loaded");

    property p_res_low_plain;
        @(posedge mclk) disable iff (rst)
        wr_l && !gen && !sample.valid |=> result_word[7:0] == $past(sfr_req.wdata);
    endproperty
    a_res_low_plain: assert property (p_res_low_plain) else $error("low byte not stored");

    property p_gain_keeps_res;
        @(posedge mclk) disable iff (rst)
        (wr_h || wr_l) && gen && !sample.valid |=> $stable(result_word);
    endproperty
    a_gain_keeps_res: assert property (p_gain_keeps_res) else $error("result hit");

    property p_read_low;
        @(posedge mclk) disable iff (rst)
        sfr_req.re && sfr_req.addr == ARF_ADDR_RES_L |=> sfr_rdata == $past(result_word[7:0]);
    endproperty
    a_read_low: assert property (p_read_low) else $error("low byte read wrong");

    property p_gain_unreadable;
        @(posedge mclk) disable iff (rst)
        sfr_req.re && (sfr_req.addr == ARF_GADDR_HIGH || sfr_req.addr == ARF_GADDR_LOW
        || sfr_req.addr == ARF_GADDR_EXTRA) |=> sfr_rdata == 8'h00;
    endproperty
    a_gain_unreadable: assert property (p_gain_unreadable) else $error("gain read back");

    property p_series_sum;
        @(posedge mclk) disable iff (rst)
        s_series_end
        |=> result_valid && result_word == $past(st_q.acc) + {4'h0, $past(sample.code)};
    endproperty
    a_series_sum: assert property (p_series_sum) else $error("series sum wrong");

    property p_series_eight;
        @(posedge mclk) disable iff (rst)
        sample.valid && rpt == ARF_RPT_8 && st_q.cnt == 4'h7 |=> result_valid && st_q.cnt == 4'h0;
    endproperty
    a_series_eight: assert property (p_series_eight) else $error("series of eight wrong");

    property p_series_sixteen;
        @(posedge mclk) disable iff (rst)
        sample.valid && rpt == ARF_RPT_16 && st_q.cnt == 4'hF |=> result_valid && st_q.cnt == 4'h0;
    endproperty
    a_series_sixteen: assert property (p_series_sixteen) else $error("series of 16 wrong");

    property p_pulse_cause;
        @(posedge mclk) disable iff (rst)
        !sample.valid |=> !result_valid;
    endproperty
    a_pulse_cause: assert property (p_pulse_cause) else $error("result pulse without sample");

    property p_cfg_fields;
        @(posedge mclk) disable iff (rst)
        sfr_req.we && sfr_req.addr == ARF_ADDR_CFG
        |=> gain_access_enable == $past(sfr_req.wdata[ARF_CFG_GAIN_ACCESS_ENABLE])
        && repeat_count_select == $past(sfr_req.wdata[ARF_CFG_RPT_HI:ARF_CFG_RPT_LO]);
    endproperty
    a_cfg_fields: assert property (p_cfg_fields) else $error("config fields wrong");

    property p_ljst_field;
        @(posedge mclk) disable iff (rst)
        sfr_req.we && sfr_req.addr == ARF_ADDR_CTL
        |=> left_justify_select == $past(sfr_req.wdata[ARF_CTL_LJST_BIT]);
    endproperty
    a_ljst_field: assert property (p_ljst_field) else $error("justify select wrong");

endmodule : arf_result_gain

/* dv/arf_cpu_model.sv */
// processor core model for the special function register port
`timescale 1ns/10ps

module arf_cpu_model
    import arf_pkg::*;
(
    input  wire logic       mclk,
    output arf_sfr_req_type sfr_req,
    input  wire logic [7:0] sfr_rdata
);
    // *****
    // bus cycles, launched and ended on the falling edge
    // *****
    initial sfr_req = '0;

    task automatic sfr_write(input logic [7:0] a, input logic [7:0] d);
        @(negedge mclk);
        sfr_req <= '{we: 1'b1, re: 1'b0, addr: a, wdata: d};
        @(negedge mclk);
        sfr_req <= '{we: 1'b0, re: 1'b0, addr: ~a, wdata: ~d};
    endtask : sfr_write

    task automatic sfr_read(input logic [7:0] a, output logic [7:0] d);
        @(negedge mclk);
        sfr_req <= '{we: 1'b0, re: 1'b1, addr: a, wdata: 8'hA5};
        @(negedge mclk);
        d = sfr_rdata;
        sfr_req <= '{we: 1'b0, re: 1'b0, addr: ~a, wdata: 8'h5A};
    endtask : sfr_read

    // *****
    // software sequences
    // *****
    task automatic gain_set(input logic [7:0] ga, input logic [7:0] v);
        sfr_write(ARF_ADDR_CFG, ARF_CFG_RST | 8'h01);
        sfr_write(ARF_ADDR_RES_H, ga);
        sfr_write(ARF_ADDR_RES_L, v);
        sfr_write(ARF_ADDR_CFG, ARF_CFG_RST);
    endtask : gain_set

    task automatic set_repeat(input logic [1:0] r);
        sfr_write(ARF_ADDR_CTL, ARF_CTL_RST);
        sfr_write(ARF_ADDR_CFG, ARF_CFG_RST | {5'h00, r, 1'b0});
    endtask : set_repeat

endmodule : arf_cpu_model

/* dv/tb_top.sv */
// testbench for the converter result and gain block
`timescale 1ns/10ps

module tb_top
    import arf_pkg::*;
;
    logic            mclk;
    logic            rst;
    arf_sfr_req_type sfr_req;
    logic [7:0]      sfr_rdata;
    arf_sample_type  sample;
    logic            result_valid;
    logic [15:0]     result_word;
    arf_gain_type    gain;
    logic            gain_access_enable;
    logic [1:0]      repeat_count_select;
    logic            left_justify_select;
    int              num_errors = 0;
    int              tests_run = 0;
    logic [11:0]     codes [4] = '{12'hFFF, 12'h800, 12'h7FF, 12'h000};
    logic [15:0]     sum;
    logic [15:0]     keep;

    arf_result_gain arf_result_gain_inst (
        .mclk(mclk), .rst(rst), .sfr_req(sfr_req), .sfr_rdata(sfr_rdata),
        .sample(sample), .result_valid(result_valid), .result_word(result_word),
        .gain(gain), .gain_access_enable(gain_access_enable),
        .repeat_count_select(repeat_count_select), .left_justify_select(left_justify_select)
    );

    arf_cpu_model arf_cpu_model_inst (
        .mclk(mclk), .sfr_req(sfr_req), .sfr_rdata(sfr_rdata)
    );

    // *****
    // helpers
    // *****
    task automatic check(input logic [15:0] seen, input logic [15:0] e);
        tests_run++;
        if (seen !== e)
        begin
            num_errors++;
            $display("unexpected at %0t: saw %h want %h", $time, seen, e);
        end
    endtask : check

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        arf_cpu_model_inst.sfr_write(a, d);
    endtask : wr

    task automatic rd_check(input logic [7:0] a, input logic [7:0] e);
        logic [7:0] d;
        arf_cpu_model_inst.sfr_read(a, d);
        check({8'h00, d}, {8'h00, e});
    endtask : rd_check

    task automatic send(input logic [11:0] c, input logic last);
        @(negedge mclk);
        sample <= '{valid: 1'b1, code: c};
        @(negedge mclk);
        sample <= '{valid: 1'b0, code: ~c};
        check(16'(result_valid), 16'(last));
    endtask : send

    task automatic tally_and_finish();
        $display("errors %0d checks %0d", num_errors, tests_run);
        if (num_errors == 0 && tests_run > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : tally_and_finish

    // *****
    // clock and watchdog
    // *****
    initial
    begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end

    initial
    begin
        #100000;
        num_errors++;
        tally_and_finish();
    end

    // *****
    // tests
    // *****
    initial
    begin
        rst = 1'b1;
        sample = '0;
        repeat (16) @(negedge mclk);
        rst = 1'b0;
        check(16'(gain.word), 16'h0FC0);
        check(16'(gain.sixtyfourth_gain_add), 16'h0001);
        check(result_word, 16'h0000);
        rd_check(ARF_ADDR_CFG, 8'hF8);
        rd_check(ARF_GADDR_HIGH, 8'h00);
        for (int lj = 0; lj < 2; lj++)
        begin
            wr(ARF_ADDR_CTL, lj ? 8'h04 : 8'h00);
            check(16'(left_justify_select), 16'(lj));
            foreach (codes[i])
            begin
                send(codes[i], 1'b1);
                keep = lj ? {codes[i], 4'h0} : {4'h0, codes[i]};
                check(result_word, keep);
                rd_check(ARF_ADDR_RES_H, keep[15:8]);
                rd_check(ARF_ADDR_RES_L, keep[7:0]);
            end
        end
        for (int r = 1; r < 4; r++)
        begin
            arf_cpu_model_inst.set_repeat(2'(r));
            check(16'(repeat_count_select), 16'(r));
            sum = 16'h0000;
            for (int k = 0; k < (2 << r); k++)
            begin
                send(12'hFFF - 12'(k * 3), k == (2 << r) - 1);
                sum += {4'h0, 12'hFFF - 12'(k * 3)};
            end
            check(result_word, sum);
        end
        arf_cpu_model_inst.set_repeat(ARF_RPT_1);
        wr(ARF_ADDR_RES_L, 8'h3C);
        check({8'h00, result_word[7:0]}, 16'h003C);
        keep = result_word;
        wr(ARF_ADDR_CFG, 8'hF9);
        check(16'(gain_access_enable), 16'h0001);
        wr(ARF_ADDR_RES_H, ARF_GADDR_HIGH);
        wr(ARF_ADDR_RES_L, 8'h6C);
        check(result_word, keep);
        check(16'(gain.word), 16'h06C0);
        rd_check(ARF_ADDR_RES_H, keep[15:8]);
        wr(ARF_ADDR_CFG, 8'hF8);
        arf_cpu_model_inst.gain_set(ARF_GADDR_LOW, 8'hA5);
        check(16'(gain.word), 16'h06CA);
        arf_cpu_model_inst.gain_set(ARF_GADDR_EXTRA, 8'h00);
        check(16'(gain.sixtyfourth_gain_add), 16'h0000);
        arf_cpu_model_inst.gain_set(8'h05, 8'h33);
        check({gain.word, 3'h0, gain.sixtyfourth_gain_add}, 16'h6CA0);
        arf_cpu_model_inst.gain_set(ARF_GADDR_HIGH, 8'hFF);
        arf_cpu_model_inst.gain_set(ARF_GADDR_LOW, 8'hF0);
        arf_cpu_model_inst.gain_set(ARF_GADDR_EXTRA, 8'h01);
        check({gain.word, 3'h0, gain.sixtyfourth_gain_add}, 16'hFFF1);
        check(16'(gain_access_enable), 16'h0000);
        tally_and_finish();
    end

endmodule : tb_top
